// ===== logic/tlm_pkg.sv
// Package for the twilight level manager: register map, fields, reset values, states.
// Assumes a 32-bit Avalon-MM slave port on one system clock.
package tlm_pkg;

  // Register byte offsets
  localparam logic [7:0] TLM_CFG_OFS      = 8'h00; // Configuration
  localparam logic [7:0] TLM_CONF_LVL_OFS = 8'h04; // Configured threshold
  localparam logic [7:0] TLM_BRIGHT_OFS   = 8'h08; // Effective brightness
  localparam logic [7:0] TLM_PRESET_OFS   = 8'h0C; // Preset object write
  localparam logic [7:0] TLM_CMD_OFS      = 8'h10; // Event commands
  localparam logic [7:0] TLM_STATUS_OFS   = 8'h14; // Status
  localparam logic [7:0] TLM_ACT_LVL_OFS  = 8'h18; // Active threshold
  localparam logic [7:0] TLM_MOTION_OFS   = 8'h1C; // Motion counts

  // Configuration field positions
  localparam int CFG_FB_IDX_LSB   = 0;  // 3 bits, block number 0..4
  localparam int CFG_APP_LSB      = 3;  // 2 bits, application type
  localparam int CFG_FB_ACTIVE    = 5;  // Feedback object active
  localparam int CFG_PRESET_EN    = 6;  // Preset object enabled
  localparam int CFG_TEACH_EN     = 7;  // Teach object enabled
  localparam int CFG_TEACH_POL_LSB = 8; // 2 bits, teach polarity
  localparam int CFG_OVERWRITE    = 10; // Overwrite on download
  localparam int CFG_BRIGHT_DEP   = 11; // Brightness-dependent evaluation
  localparam int CFG_EXT_DEP      = 12; // Ext motion brightness-dependent
  localparam int CFG_RET_DELAY_LSB = 16; // 8 bits, return send delay (cycles)

  // Command bits
  localparam int CMD_DOWNLOAD    = 0;
  localparam int CMD_BUS_RETURN  = 1;
  localparam int CMD_TEACH       = 2;
  localparam int CMD_TEACH_VAL   = 3;
  localparam int CMD_IR_SET      = 4;
  localparam int CMD_DEACT       = 5;
  localparam int CMD_DEACT_VAL   = 6;
  localparam int CMD_EXT_MOTION  = 7;
  localparam int CMD_MANUAL      = 8;
  localparam int CMD_MANUAL_VAL  = 9;
  localparam int CMD_SEND_ACK    = 10;

  // Reset values
  localparam logic [31:0] TLM_CFG_RST      = 32'h0000_0860;
  localparam logic [15:0] TLM_CONF_LVL_RST = 16'h0C00;

  // Teach polarity codes
  localparam logic [1:0] TLM_POL_ONE  = 2'h1;
  localparam logic [1:0] TLM_POL_ZERO = 2'h2;
  localparam logic [1:0] TLM_POL_BOTH = 2'h3;

  // Application types
  typedef enum logic [1:0] {
    TLM_APP_SINGLE = 2'h0,
    TLM_APP_MAIN   = 2'h1,
    TLM_APP_EXT    = 2'h2
  } tlm_app_t;

  // Feedback sender states, Gray along idle -> wait -> send
  typedef enum logic [1:0] {
    TLM_FB_IDLE = 2'b00,
    TLM_FB_WAIT = 2'b01,
    TLM_FB_SEND = 2'b11
  } tlm_fb_state_t;

  // Avalon request carrier
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
  } tlm_av_req_t;

endpackage : tlm_pkg

// ===== logic/tlm_twilight_level.sv
// Twilight level manager for one motion function block.
// Assumes an Avalon-MM master on clk_sys_i; bus telegrams arrive as register commands.
// Functional notes
// R1: Active level exposed as 2-byte brightness object
// R2: Active feedback sends on change, download, return
// R3: Enabled preset object replaces the threshold
// R4: External or taught level persists across failures
// R5: Disable function never blocks preset or teach
// R6: Teach adopts current effective brightness immediately
// R7: Opposite teach value restores configured level
// R8: Download with overwrite restores configured level
// R9: Configured level used until first external set
// R10: Remote control sets only block one
// R11: Main unit gates external motion by brightness
// R12: Single device gates external motion by brightness
// R13: Independent evaluation accepts every external motion
// R14: Extension has no external motion input
// R15: Deactivation 1 disables, 0 enables evaluation
// R16: No automatic return to dependent evaluation
// R17: Main unit drives extensions' deactivation output
// R18: Main unit output silent while externally deactivated
// R19: Single or main unit accepts manual on/off
// R20: Dependent motion accepted only below threshold
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
module tlm_twilight_level
  import tlm_pkg::*;
#(
  parameter int LVL_W = 16 // Width of brightness values
) (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  // Avalon-MM slave
  input  wire logic [7:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // Sensor side
  input  wire logic              int_motion_i,
  // Outputs toward the bus stack
  output logic                   fb_send_o,
  output logic [LVL_W-1:0]       fb_level_o,
  output logic                   deact_send_o,
  output logic                   deact_val_o,
  output logic                   motion_o,
  output logic                   manual_o,
  output logic                   manual_val_o
);

  // Request capture and one-cycle wait
  tlm_av_req_t            req;                // Bus request bundle
  logic                   ack_reg;            // Answer cycle marker
  logic [31:0]            wmask;              // Byte lane mask
  // Stored configuration and values
  logic [31:0]            cfg_reg;            // Configuration word
  logic [LVL_W-1:0]       conf_lvl_reg;       // Configured threshold
  logic [LVL_W-1:0]       bright_reg;         // Effective brightness
  logic [LVL_W-1:0]       act_lvl_reg;        // Active threshold
  logic                   ext_set_reg;        // Externally set flag
  logic                   deact_reg;          // Evaluation switched off
  logic [15:0]            acc_cnt_reg;        // Accepted external motions
  logic [15:0]            drop_cnt_reg;       // Discarded external motions
  // Feedback sender
  tlm_fb_state_t          fb_state_reg;       // Sender state
  logic [7:0]             fb_dly_reg;         // Return delay count
  logic                   fb_pend_reg;        // Unacknowledged send seen
  // Decoded write events
  logic                   wr_cycle;           // Write taken this cycle
  logic [31:0]            cmd;                // Command bits when written
  logic                   preset_wr;          // Preset object write
  logic                   teach_set;          // Teach to brightness
  logic                   teach_restore;      // Teach opposite value
  logic                   ir_set;             // Remote set accepted
  logic                   dl_restore;         // Download overwrites
  logic [LVL_W-1:0]       lvl_next;           // Next active level
  logic                   lvl_chg;            // Level changes
  logic                   dep_eval;           // Dependent evaluation in force
  logic                   bright_ok;          // Brightness below threshold
  logic                   ext_ok;             // External motion accepted
  tlm_app_t               app;                // Application type

  // One driver for the whole bundle, so no field is driven apart from the rest
  assign req           = '{read: avs_read_i, write: avs_write_i, address: avs_address_i,
                           writedata: avs_writedata_i};
  assign app           = tlm_app_t'(cfg_reg[CFG_APP_LSB +: 2]);
  assign wr_cycle      = req.write && ack_reg;
  assign cmd           = (wr_cycle && req.address == TLM_CMD_OFS) ? req.writedata : 32'h0000_0000;

  // Byte lane mask from byte enables
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable_i[i]}};
    end
  end

  // Answer one cycle after a request appears; waitrequest low only in the answer cycle
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ack_reg           <= 1'b0;
      avs_waitrequest_o <= 1'b1; // Busy while in reset
    end else begin
      ack_reg           <= (req.read || req.write) && !ack_reg;
      avs_waitrequest_o <= !((req.read || req.write) && !ack_reg); // Flopped inverse of the answer
    end
  end

  // Read data, registered at request arrival so it stands with waitrequest low
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (req.read && !ack_reg) begin
      unique case (req.address)
        TLM_CFG_OFS:      avs_readdata_o <= cfg_reg;
        TLM_CONF_LVL_OFS: avs_readdata_o <= 32'(conf_lvl_reg);
        TLM_BRIGHT_OFS:   avs_readdata_o <= 32'(bright_reg);
        TLM_STATUS_OFS:   avs_readdata_o <= {28'h0000000, fb_pend_reg, deact_reg, dep_eval, ext_set_reg};
        TLM_ACT_LVL_OFS:  avs_readdata_o <= 32'(act_lvl_reg); // Passive status read [R1]
        TLM_MOTION_OFS:   avs_readdata_o <= {drop_cnt_reg, acc_cnt_reg};
        default:          avs_readdata_o <= 32'h0000_0000; // Unmapped and write-only read zero
      endcase
    end
  end

  // Configuration and brightness registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cfg_reg      <= TLM_CFG_RST;
      conf_lvl_reg <= TLM_CONF_LVL_RST;
      bright_reg   <= '0;
    end else if (wr_cycle) begin
      if (req.address == TLM_CFG_OFS) begin
        cfg_reg <= (cfg_reg & ~wmask) | (req.writedata & wmask);
      end
      if (req.address == TLM_CONF_LVL_OFS) begin
        conf_lvl_reg <= LVL_W'((32'(conf_lvl_reg) & ~wmask) | (req.writedata & wmask));
      end
      if (req.address == TLM_BRIGHT_OFS) begin
        bright_reg <= LVL_W'((32'(bright_reg) & ~wmask) | (req.writedata & wmask));
      end
    end
  end

  // Level update sources, none gated by the disable function [R5]
  assign preset_wr     = wr_cycle && req.address == TLM_PRESET_OFS && cfg_reg[CFG_PRESET_EN]; // [R3]
  assign teach_set     = cmd[CMD_TEACH] && cfg_reg[CFG_TEACH_EN] &&
                         ((cmd[CMD_TEACH_VAL] && cfg_reg[CFG_TEACH_POL_LSB]) ||
                          (!cmd[CMD_TEACH_VAL] && cfg_reg[CFG_TEACH_POL_LSB+1])); // [R6]
  assign teach_restore = cmd[CMD_TEACH] && cfg_reg[CFG_TEACH_EN] && !teach_set &&
                         cfg_reg[CFG_TEACH_POL_LSB +: 2] != TLM_POL_BOTH; // [R7]
  assign ir_set        = cmd[CMD_IR_SET] && cfg_reg[CFG_FB_IDX_LSB +: 3] == 3'h0; // [R10]
  assign dl_restore    = cmd[CMD_DOWNLOAD] && (cfg_reg[CFG_OVERWRITE] || !ext_set_reg); // [R8] [R9]

  // Next active level, priority preset, teach, remote, restore
  always_comb begin
    lvl_next = act_lvl_reg;
    if (preset_wr) begin
      lvl_next = req.writedata[LVL_W-1:0]; // [R3]
    end else if (teach_set) begin
      lvl_next = bright_reg; // [R6]
    end else if (ir_set) begin
      lvl_next = cmd[31:32-LVL_W]; // Remote value in upper half
    end else if (teach_restore || dl_restore) begin
      lvl_next = conf_lvl_reg; // [R7] [R8]
    end
  end
  assign lvl_chg = lvl_next != act_lvl_reg;

  // Active level; held over bus voltage return, only reset or a teach or download restore sets it back [R4]
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      act_lvl_reg <= TLM_CONF_LVL_RST;
    end else begin
      act_lvl_reg <= lvl_next;
    end
  end

  // External-set flag; learned value discarded by restore [R9] [R7]
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ext_set_reg <= 1'b0;
    end else if (preset_wr || teach_set || ir_set) begin
      ext_set_reg <= 1'b1; // [R4]
    end else if (teach_restore || dl_restore) begin
      ext_set_reg <= 1'b0;
    end
  end

  // Deactivation input, stays until told otherwise [R15] [R16]
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      deact_reg <= 1'b0;
    end else if (cmd[CMD_DEACT]) begin
      deact_reg <= cmd[CMD_DEACT_VAL]; // [R15]
    end
  end

  // Brightness gating of motions
  assign dep_eval  = cfg_reg[CFG_BRIGHT_DEP] && !deact_reg; // [R13] [R15]
  assign bright_ok = bright_reg < act_lvl_reg; // [R20]
  always_comb begin
    ext_ok = 1'b0;
    unique case (app)
      TLM_APP_SINGLE, TLM_APP_MAIN: begin
        ext_ok = !dep_eval || !cfg_reg[CFG_EXT_DEP] || bright_ok; // [R11] [R12] [R13]
      end
      default: begin
        ext_ok = 1'b0; // Extension has no external input [R14]
      end
    endcase
  end

  // Motion output and external motion counters
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      motion_o     <= 1'b0;
      acc_cnt_reg  <= 16'h0000;
      drop_cnt_reg <= 16'h0000;
    end else begin
      motion_o <= (int_motion_i && (!dep_eval || bright_ok)) || (cmd[CMD_EXT_MOTION] && ext_ok); // [R20]
      if (cmd[CMD_EXT_MOTION] && ext_ok) begin
        acc_cnt_reg <= acc_cnt_reg + 16'h0001;
      end else if (cmd[CMD_EXT_MOTION]) begin
        drop_cnt_reg <= drop_cnt_reg + 16'h0001;
      end
    end
  end

  // Manual lighting object for single device and main unit
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      manual_o     <= 1'b0;
      manual_val_o <= 1'b0;
    end else begin
      manual_o <= cmd[CMD_MANUAL] && app != TLM_APP_EXT; // [R19]
      if (cmd[CMD_MANUAL] && app != TLM_APP_EXT) begin
        manual_val_o <= cmd[CMD_MANUAL_VAL];
      end
    end
  end

  // Main unit deactivation output follows its own evaluation
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      deact_send_o <= 1'b0;
      deact_val_o  <= 1'b0;
    end else begin
      deact_send_o <= 1'b0;
      if (app == TLM_APP_MAIN && !deact_reg) begin // Silent while deactivated [R18]
        if (cmd[CMD_EXT_MOTION] || int_motion_i) begin
          deact_send_o <= 1'b1; // [R17]
          deact_val_o  <= !bright_ok;
        end
      end
    end
  end

  // Feedback sender: change sends now, return waits the delay [R2]
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fb_state_reg <= TLM_FB_IDLE;
      fb_dly_reg   <= 8'h00;
      fb_send_o    <= 1'b0;
      fb_level_o   <= '0;
    end else begin
      fb_send_o <= 1'b0;
      unique case (fb_state_reg)
        TLM_FB_IDLE: begin
          if (cfg_reg[CFG_FB_ACTIVE] && cmd[CMD_BUS_RETURN]) begin
            fb_dly_reg   <= cfg_reg[CFG_RET_DELAY_LSB +: 8];
            fb_state_reg <= TLM_FB_WAIT;
          end else if (cfg_reg[CFG_FB_ACTIVE] && (lvl_chg || cmd[CMD_DOWNLOAD])) begin
            fb_state_reg <= TLM_FB_SEND;
          end
        end
        TLM_FB_WAIT: begin
          if (fb_dly_reg == 8'h00) begin
            fb_state_reg <= TLM_FB_SEND;
          end else begin
            fb_dly_reg <= fb_dly_reg - 8'h01;
          end
        end
        TLM_FB_SEND: begin
          fb_send_o    <= 1'b1; // [R1] [R2]
          fb_level_o   <= act_lvl_reg;
          fb_state_reg <= TLM_FB_IDLE;
        end
      endcase
    end
  end

  // Pending flag: set by a send, cleared by ack; set wins
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fb_pend_reg <= 1'b0;
    end else if (fb_state_reg == TLM_FB_SEND) begin
      fb_pend_reg <= 1'b1;
    end else if (cmd[CMD_SEND_ACK]) begin
      fb_pend_reg <= 1'b0;
    end
  end

endmodule : tlm_twilight_level

// ===== bench/tlm_bus_peer.sv
// Bus stack peer: receives the feedback telegrams of the level manager.
// Assumes fb_send_i is a one-cycle pulse with fb_level_i valid at that edge.
module tlm_bus_peer (
  // Clock
  input  wire logic        clk_sys_i,
  // Telegram from the block
  input  wire logic        fb_send_i,
  input  wire logic [15:0] fb_level_i,
  // Observations for the bench
  output int               n_fb_o,
  output logic [15:0]      last_lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial n_fb_o = 0;
  initial last_lvl_o = 16'h0000;
  // Latch each level telegram once per pulse
  always @(posedge clk_sys_i) begin
    if (fb_send_i === 1'b1) begin
      n_fb_o <= n_fb_o + 1;
      last_lvl_o <= fb_level_i;
    end
  end
endmodule : tlm_bus_peer

// ===== bench/tlm_checker.sv
// Port checker for the twilight level manager.
// Assumes one clock and a synchronous active-high reset.
module tlm_checker
  import tlm_pkg::*;
#(
  parameter int LVL_W = 16 // Width of brightness values
) (
  // All ports of the block, watched only
  input wire logic             clk_sys_i,
  input wire logic             reset_i,
  input wire logic [7:0]       avs_address_i,
  input wire logic             avs_read_i,
  input wire logic             avs_write_i,
  input wire logic [31:0]      avs_writedata_i,
  input wire logic [3:0]       avs_byteenable_i,
  input wire logic [31:0]      avs_readdata_o,
  input wire logic             avs_waitrequest_o,
  input wire logic             int_motion_i,
  input wire logic             fb_send_o,
  input wire logic [LVL_W-1:0] fb_level_o,
  input wire logic             deact_send_o,
  input wire logic             deact_val_o,
  input wire logic             motion_o,
  input wire logic             manual_o,
  input wire logic             manual_val_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Steps of one bus cycle
  sequence req_rise;
    $rose(avs_read_i || avs_write_i);
  endsequence
  sequence ans_cyc;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  wait_one_a: assert property (req_rise |=> ans_cyc) else $error("bus answer not one cycle");
  wait_idle_a: assert property (!(avs_read_i || avs_write_i) |-> avs_waitrequest_o) else $error("idle ack");
  rdata_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o)) else $error("readdata moved");
  wo_read_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == TLM_PRESET_OFS
    |-> avs_readdata_o == 32'h0000_0000) else $error("preset reads back");
  bad_addr_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 8'h1F
    |-> avs_readdata_o == 32'h0000_0000) else $error("unmapped read");
  fb_pulse_a: assert property (fb_send_o |=> !fb_send_o) else $error("feedback not a pulse");
  deact_pulse_a: assert property (deact_send_o |=> !deact_send_o) else $error("deact not a pulse");
  man_pulse_a: assert property (manual_o |=> !manual_o) else $error("manual not a pulse");
endmodule : tlm_checker

bind tlm_twilight_level tlm_checker #(.LVL_W(LVL_W)) u_chk (.clk_sys_i, .reset_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .int_motion_i,
  .fb_send_o, .fb_level_o, .deact_send_o, .deact_val_o, .motion_o, .manual_o, .manual_val_o);

// ===== bench/tb.sv
// Self-checking bench for the twilight level manager.
// Assumes an Avalon slave with waitrequest; the master waits for it to go low.
module tb
  import tlm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0, int_motion_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic avs_waitrequest_o, fb_send_o, deact_send_o, deact_val_o, motion_o, manual_o, manual_val_o;
  logic [15:0] fb_level_o, last_lvl;
  int n_mismatch = 0, checked = 0, n_mot = 0, n_man = 0, n_ds = 0, n_fb;
  // 10 MHz clock
  always #50 clk_sys_i = ~clk_sys_i;
  tlm_twilight_level dut (.clk_sys_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .int_motion_i, .fb_send_o, .fb_level_o,
    .deact_send_o, .deact_val_o, .motion_o, .manual_o, .manual_val_o);
  tlm_bus_peer u_peer (.clk_sys_i, .fb_send_i(fb_send_o), .fb_level_i(fb_level_o), .n_fb_o(n_fb),
    .last_lvl_o(last_lvl));
  // Count accepted motions and manual telegrams
  always @(posedge clk_sys_i) begin
    if (motion_o === 1'b1) n_mot <= n_mot + 1;
    if (manual_o === 1'b1) n_man <= n_man + 1;
    if (deact_send_o === 1'b1) n_ds <= n_ds + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One Avalon cycle; request held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    avs_read_i <= rd;
    avs_write_i <= !rd;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b1, a, 32'h0);
    chk(q, e);
  endtask : rc
  // Command write, then let its effect settle
  task automatic cmd(input logic [31:0] d);
    wr(TLM_CMD_OFS, d);
    repeat (4) @(posedge clk_sys_i);
  endtask : cmd
  task automatic t_reset;
    rc(TLM_ACT_LVL_OFS, 32'h0000_0C00);
    rc(TLM_CONF_LVL_OFS, {16'h0, TLM_CONF_LVL_RST});
    rc(TLM_PRESET_OFS, 32'h0);
    rc(8'h20, 32'h0);
  endtask : t_reset
  task automatic t_preset;
    int f0 = n_fb;
    wr(TLM_PRESET_OFS, 32'h0000_0500);
    repeat (3) @(posedge clk_sys_i);
    rc(TLM_ACT_LVL_OFS, 32'h0000_0500);
    chk(n_fb - f0, 1);
    chk({16'h0, last_lvl}, 32'h0000_0500);
    cmd(32'h60);
    wr(TLM_PRESET_OFS, 32'h0000_0600);
    rc(TLM_ACT_LVL_OFS, 32'h0000_0600);
    cmd(32'h20);
    wr(TLM_CFG_OFS, 32'h0000_0820);
    wr(TLM_PRESET_OFS, 32'h0000_0700);
    rc(TLM_ACT_LVL_OFS, 32'h0000_0600);
  endtask : t_preset
  task automatic t_teach;
    wr(TLM_CFG_OFS, 32'h0000_09E0);
    wr(TLM_BRIGHT_OFS, 32'h0000_0300);
    cmd(32'h0C);
    rc(TLM_ACT_LVL_OFS, 32'h0000_0300);
    cmd(32'h04);
    rc(TLM_ACT_LVL_OFS, 32'h0000_0C00);
    wr(TLM_CFG_OFS, 32'h0000_0BE0);
    wr(TLM_BRIGHT_OFS, 32'h0000_0200);
    cmd(32'h04);
    rc(TLM_ACT_LVL_OFS, 32'h0000_0200);
  endtask : t_teach
  task automatic t_download;
    int f0;
    wr(TLM_CFG_OFS, 32'h0000_0860);
    wr(TLM_PRESET_OFS, 32'h0000_0400);
    cmd(32'h01);
    rc(TLM_ACT_LVL_OFS, 32'h0000_0400);
    f0 = n_fb;
    cmd(32'h02);
    chk(n_fb - f0, 1);
    rc(TLM_ACT_LVL_OFS, 32'h0000_0400);
    wr(TLM_CFG_OFS, 32'h0005_0860);
    f0 = n_fb;
    cmd(32'h02);
    chk(n_fb - f0, 0);
    repeat (4) @(posedge clk_sys_i);
    chk(n_fb - f0, 1);
    wr(TLM_CFG_OFS, 32'h0000_0C60);
    cmd(32'h01);
    rc(TLM_ACT_LVL_OFS, 32'h0000_0C00);
  endtask : t_download
  task automatic t_ir;
    wr(TLM_CFG_OFS, 32'h0000_0861);
    cmd(32'h0777_0010);
    rc(TLM_ACT_LVL_OFS, 32'h0000_0C00);
    wr(TLM_CFG_OFS, 32'h0000_0860);
    cmd(32'h0777_0010);
    rc(TLM_ACT_LVL_OFS, 32'h0000_0777);
  endtask : t_ir
  // External motion gating by brightness, mode and application
  task automatic t_motion;
    int m0 = n_mot;
    wr(TLM_CFG_OFS, 32'h0000_1C60);
    cmd(32'h01);
    wr(TLM_BRIGHT_OFS, 32'h0000_0F00);
    cmd(32'h80);
    chk(n_mot - m0, 0);
    wr(TLM_BRIGHT_OFS, 32'h0000_0100);
    cmd(32'h80);
    chk(n_mot - m0, 1);
    wr(TLM_BRIGHT_OFS, 32'h0000_0F00);
    wr(TLM_CFG_OFS, 32'h0000_0C60);
    cmd(32'h80);
    chk(n_mot - m0, 2);
    wr(TLM_CFG_OFS, 32'h0000_1C60);
    cmd(32'h60);
    cmd(32'h80);
    cmd(32'h80);
    chk(n_mot - m0, 4);
    cmd(32'h20);
    cmd(32'h80);
    chk(n_mot - m0, 4);
    wr(TLM_CFG_OFS, 32'h0000_1C68);
    cmd(32'h80);
    chk(n_mot - m0, 4);
    wr(TLM_CFG_OFS, 32'h0000_0C68);
    cmd(32'h80);
    chk(n_mot - m0, 5);
    chk(n_ds, 2);
    chk(deact_val_o, 1);
    wr(TLM_CFG_OFS, 32'h0000_1C68);
    wr(TLM_BRIGHT_OFS, 32'h0000_0100);
    cmd(32'h80);
    chk(n_ds, 3);
    chk(deact_val_o, 0);
    cmd(32'h60);
    cmd(32'h80);
    chk(n_ds, 3);
    chk(n_mot - m0, 7);
    cmd(32'h20);
    wr(TLM_CFG_OFS, 32'h0000_1C70);
    cmd(32'h80);
    chk(n_mot - m0, 7);
  endtask : t_motion
  // Manual object on a single device, internal motion gating, then manual object on an extension
  task automatic t_manual;
    int m0 = n_mot;
    wr(TLM_CFG_OFS, 32'h0000_0860);
    cmd(32'h300);
    chk(manual_val_o, 1);
    cmd(32'h100);
    chk(manual_val_o, 0);
    chk(n_man, 2);
    int_motion_i <= 1'b1;
    @(posedge clk_sys_i);
    int_motion_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk(n_mot - m0, 1);
    wr(TLM_BRIGHT_OFS, 32'h0000_0F00);
    int_motion_i <= 1'b1;
    @(posedge clk_sys_i);
    int_motion_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk(n_mot - m0, 1);
    wr(TLM_CFG_OFS, 32'h0000_0870);
    cmd(32'h300);
    chk(n_man, 2);
    chk(manual_val_o, 0);
  endtask : t_manual
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #2_000_000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_reset();
    $display("reset test done");
    t_preset();
    $display("preset test done");
    t_teach();
    $display("teach test done");
    t_download();
    $display("download test done");
    t_ir();
    $display("remote test done");
    t_motion();
    $display("motion test done");
    t_manual();
    $display("manual test done");
    conclude();
  end
endmodule : tb
